// ==== hdl/sgc_pkg.sv ====
package sgc_pkg;

	// ****************************************
	// register map
	// ****************************************
	localparam logic [7:0]  ADDR_GAIN      = 8'hc6;
	localparam logic [7:0]  ADDR_CFG       = 8'hc7;
	localparam logic [15:0] GAIN_RESET     = 16'h0000;
	localparam logic [15:0] CFG_RESET      = 16'h0000;
	localparam logic [15:0] CFG_WMASK      = 16'hff00;
	localparam int          CFG_EN_BIT     = 15;
	localparam int          CFG_POL_BIT    = 14;
	localparam int          CFG_NUM_LSB    = 8;
	localparam int          CFG_NUM_MSB    = 12;

	// ****************************************
	// gain and data widths
	// ****************************************
	localparam int                 CONV_W     = 24;
	localparam int                 GAIN_SHIFT = 16;
	localparam logic signed [17:0] GAIN_UNITY = 18'sh10000;
	localparam logic signed [25:0] CAL_MAX    = 26'sh07fffff;
	localparam logic signed [25:0] CAL_MIN    = -26'sh0800000;

	// ****************************************
	// fast filter and comparator
	// ****************************************
	localparam int          FF_OSR       = 64;
	localparam int          FF_DCNT_W    = 6;
	localparam int          FF_W         = 20;
	localparam int          FF_RES_LSB   = 4;
	localparam logic [15:0] TH_HI_OFF    = 16'h7fff;
	localparam logic [15:0] TH_LO_OFF    = 16'h8000;
	localparam logic [7:0]  TRIP_CNT_MAX = 8'hff;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  addr;
		logic [15:0] wdata;
	} sgc_reg_req_t;

	typedef struct packed {
		logic [15:0]              gain;
		logic [15:0]              cfg;
		logic [15:0]              rdata;
		logic [CONV_W-1:0]        cal_data;
		logic                     cal_valid;
		logic [1:0]               conv_cnt;
		logic [FF_W-1:0]          i1;
		logic [FF_W-1:0]          i2;
		logic [FF_W-1:0]          i3;
		logic [FF_W-1:0]          d1;
		logic [FF_W-1:0]          d2;
		logic [FF_W-1:0]          d3;
		logic [FF_DCNT_W-1:0]     dcnt;
		logic [15:0]              ff_res;
		logic                     ff_valid;
		logic [7:0]               cnt_h;
		logic [7:0]               cnt_l;
		logic                     flag_h;
		logic                     flag_l;
		logic                     pin_o;
		logic                     pin_oe;
	} sgc_state_t;

	// deglitch code to number of consecutive results
	function automatic logic [7:0] trip_count(input logic [4:0] code);
		logic [7:0] n;
		n = 8'h01;
		unique case (code)
			5'h08: n = 8'h09;
			5'h09: n = 8'h0a;
			5'h0a: n = 8'h0c;
			5'h0b: n = 8'h0e;
			5'h0c: n = 8'h10;
			5'h0d: n = 8'h12;
			5'h0e: n = 8'h14;
			5'h0f: n = 8'h16;
			5'h10: n = 8'h18;
			5'h11: n = 8'h1c;
			5'h12: n = 8'h20;
			5'h13: n = 8'h24;
			5'h14: n = 8'h28;
			5'h15: n = 8'h30;
			5'h16: n = 8'h38;
			5'h17: n = 8'h40;
			5'h18: n = 8'h48;
			5'h19: n = 8'h50;
			5'h1a: n = 8'h58;
			5'h1b: n = 8'h60;
			5'h1c: n = 8'h68;
			5'h1d: n = 8'h70;
			5'h1e: n = 8'h78;
			5'h1f: n = 8'h80;
			default: n = {3'h0, code} + 8'h01;
		endcase
		return n;
	endfunction

endpackage

// ==== hdl/sgc_shunt_cal.sv ====
// Overview of operation
// - gain word is signed, one step is 1/65536, zero means unity gain
// - word 0 gives 1, 7fff gives 1.499985, 8000 gives 0.5
// - comparator enable runs fast filter and comparator; clear stops both
// - fast filter ignores start and stop bits; the enable, converter enable and standby gate it
// - fast filter is sinc3 with fixed decimation of 64
// - trip asserts only after the selected number of consecutive results beyond
// - count code 0..7 maps to code+1, above that stepped up to 128
// - one result back inside restarts the count; no hysteresis
// - fault is active when either trip flag is active
// - polarity 1 drives fault high, polarity 0 drives fault low
// - fault reaches shared pin only if selected; pin format sets drive
// - result above high threshold counts; 7fff disables high detection
// - result below low threshold counts; 8000 disables low detection
// - converter off or standby clears conversion data and its counter
module sgc_shunt_cal (
	input  logic                   sys_clk_i,
	input  logic                   nrst_i,
	input  sgc_pkg::sgc_reg_req_t  reg_req_i,
	output logic [15:0]            reg_rdata_o,
	input  logic                   conv_enable_i,
	input  logic                   standby_i,
	input  logic                   conv_valid_i,
	input  logic [23:0]            conv_data_i,
	output logic                   cal_valid_o,
	output logic [23:0]            cal_data_o,
	output logic [1:0]             conv_count_o,
	input  logic                   mod_stb_i,
	input  logic                   mod_bit_i,
	input  logic [15:0]            high_trip_threshold_i,
	input  logic [15:0]            low_trip_threshold_i,
	output logic                   high_trip_flag_o,
	output logic                   low_trip_flag_o,
	input  logic                   shared_pin_source_select_i,
	input  logic                   shared_pin_format_i,
	input  logic                   gpio_data_i,
	output logic                   overcurrent_fault_pin_o,
	output logic                   overcurrent_fault_pin_oe_o
);

	sgc_pkg::sgc_state_t st_r;
	sgc_pkg::sgc_state_t st_nxt;

	logic                     comp_en;
	logic                     fault_pol;
	logic [7:0]               trip_n;
	logic                     ff_run;
	logic signed [17:0]       factor;
	logic signed [41:0]       prod;
	logic signed [25:0]       scaled;
	logic [sgc_pkg::FF_W-1:0] x_in;
	logic [sgc_pkg::FF_W-1:0] c1;
	logic [sgc_pkg::FF_W-1:0] c2;
	logic [sgc_pkg::FF_W-1:0] c3;
	logic [7:0]               cnt_inc_h;
	logic [7:0]               cnt_inc_l;
	logic                     fault;
	logic                     level;
	logic                     drive;

	assign comp_en   = st_r.cfg[sgc_pkg::CFG_EN_BIT];
	assign fault_pol = st_r.cfg[sgc_pkg::CFG_POL_BIT];
	assign trip_n    = sgc_pkg::trip_count(st_r.cfg[sgc_pkg::CFG_NUM_MSB:sgc_pkg::CFG_NUM_LSB]);

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		st_nxt = st_r;
		st_nxt.cal_valid = 1'b0;
		st_nxt.ff_valid  = 1'b0;

		// register port; reserved low byte of config is never stored
		if (reg_req_i.wr) begin
			if (reg_req_i.addr == sgc_pkg::ADDR_GAIN) begin
				st_nxt.gain = reg_req_i.wdata;
			end else if (reg_req_i.addr == sgc_pkg::ADDR_CFG) begin
				st_nxt.cfg = reg_req_i.wdata & sgc_pkg::CFG_WMASK;
			end
		end
		if (reg_req_i.rd) begin
			unique case (reg_req_i.addr)
				sgc_pkg::ADDR_GAIN: st_nxt.rdata = st_r.gain;
				sgc_pkg::ADDR_CFG:  st_nxt.rdata = st_r.cfg & sgc_pkg::CFG_WMASK;
				default:            st_nxt.rdata = 16'h0000;
			endcase
		end

		// gain calibration: factor = 1 + word/65536
		factor = sgc_pkg::GAIN_UNITY + 18'(signed'(st_r.gain));
		prod   = 42'(signed'(conv_data_i)) * 42'(factor);
		scaled = prod[41:sgc_pkg::GAIN_SHIFT];
		if (conv_valid_i) begin
			if (scaled > sgc_pkg::CAL_MAX) begin
				st_nxt.cal_data = sgc_pkg::CAL_MAX[23:0];
			end else if (scaled < sgc_pkg::CAL_MIN) begin
				st_nxt.cal_data = sgc_pkg::CAL_MIN[23:0];
			end else begin
				st_nxt.cal_data = scaled[23:0];
			end
			st_nxt.cal_valid = 1'b1;
			st_nxt.conv_cnt  = st_r.conv_cnt + 2'h1;
		end
		if (!conv_enable_i || standby_i) begin
			st_nxt.cal_data  = '0;
			st_nxt.cal_valid = 1'b0;
			st_nxt.conv_cnt  = 2'h0;
		end

		// sinc3 fast filter; start/stop bits deliberately not looked at
		ff_run = comp_en && conv_enable_i && !standby_i;
		x_in   = mod_bit_i ? sgc_pkg::FF_W'(1) : '1;
		c1     = st_r.i3 - st_r.d1;
		c2     = c1 - st_r.d2;
		c3     = c2 - st_r.d3;
		if (mod_stb_i) begin
			st_nxt.i1   = st_r.i1 + x_in;
			st_nxt.i2   = st_r.i2 + st_r.i1;
			st_nxt.i3   = st_r.i3 + st_r.i2;
			st_nxt.dcnt = st_r.dcnt + sgc_pkg::FF_DCNT_W'(1);
			if (st_r.dcnt == sgc_pkg::FF_DCNT_W'(sgc_pkg::FF_OSR - 1)) begin
				st_nxt.d1       = st_r.i3;
				st_nxt.d2       = c1;
				st_nxt.d3       = c2;
				st_nxt.ff_res   = c3[sgc_pkg::FF_W-1:sgc_pkg::FF_RES_LSB];
				st_nxt.ff_valid = 1'b1;
			end
		end

		// comparator with deglitch counters, once per filter output
		cnt_inc_h = (st_r.cnt_h == sgc_pkg::TRIP_CNT_MAX) ? st_r.cnt_h : st_r.cnt_h + 8'h01;
		cnt_inc_l = (st_r.cnt_l == sgc_pkg::TRIP_CNT_MAX) ? st_r.cnt_l : st_r.cnt_l + 8'h01;
		if (st_r.ff_valid) begin
			if (high_trip_threshold_i != sgc_pkg::TH_HI_OFF &&
			    $signed(st_r.ff_res) > $signed(high_trip_threshold_i)) begin
				st_nxt.cnt_h  = cnt_inc_h;
				st_nxt.flag_h = (cnt_inc_h >= trip_n);
			end else begin
				st_nxt.cnt_h  = 8'h00;
				st_nxt.flag_h = 1'b0;
			end
			if (low_trip_threshold_i != sgc_pkg::TH_LO_OFF &&
			    $signed(st_r.ff_res) < $signed(low_trip_threshold_i)) begin
				st_nxt.cnt_l  = cnt_inc_l;
				st_nxt.flag_l = (cnt_inc_l >= trip_n);
			end else begin
				st_nxt.cnt_l  = 8'h00;
				st_nxt.flag_l = 1'b0;
			end
		end

		// idle filter is held cleared so a re-enable starts from a clean state
		if (!ff_run) begin
			st_nxt.i1       = '0;
			st_nxt.i2       = '0;
			st_nxt.i3       = '0;
			st_nxt.d1       = '0;
			st_nxt.d2       = '0;
			st_nxt.d3       = '0;
			st_nxt.dcnt     = '0;
			st_nxt.ff_res   = '0;
			st_nxt.ff_valid = 1'b0;
			st_nxt.cnt_h    = 8'h00;
			st_nxt.cnt_l    = 8'h00;
			st_nxt.flag_h   = 1'b0;
			st_nxt.flag_l   = 1'b0;
		end

		// fault pin
		fault = st_r.flag_h || st_r.flag_l;
		level = fault_pol ? fault : !fault;
		drive = shared_pin_source_select_i ? level : gpio_data_i;
		if (shared_pin_format_i) begin
			st_nxt.pin_o  = 1'b0;
			st_nxt.pin_oe = !drive;
		end else begin
			st_nxt.pin_o  = drive;
			st_nxt.pin_oe = 1'b1;
		end
	end

	// ****************************************
	// state register
	// ****************************************
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st_r      <= '0;
			st_r.gain <= sgc_pkg::GAIN_RESET;
			st_r.cfg  <= sgc_pkg::CFG_RESET;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign reg_rdata_o                = st_r.rdata;
	assign cal_valid_o                = st_r.cal_valid;
	assign cal_data_o                 = st_r.cal_data;
	assign conv_count_o               = st_r.conv_cnt;
	assign high_trip_flag_o           = st_r.flag_h;
	assign low_trip_flag_o            = st_r.flag_l;
	assign overcurrent_fault_pin_o    = st_r.pin_o;
	assign overcurrent_fault_pin_oe_o = st_r.pin_oe;

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!nrst_i);

	a_gain_unity: assert property (
		conv_valid_i && conv_enable_i && !standby_i && st_r.gain == 16'h0000
		|=> cal_valid_o && cal_data_o == $past(conv_data_i))
		else $error("unity gain changed the data");
	a_gain_half: assert property (
		conv_valid_i && conv_enable_i && !standby_i && st_r.gain == 16'h8000
		|=> $signed(cal_data_o) == ($signed($past(conv_data_i)) >>> 1))
		else $error("minimum gain is not one half");
	a_gain_sat: assert property (
		conv_valid_i && conv_enable_i && !standby_i && !st_r.gain[15] &&
		conv_data_i == 24'h7fffff |=> cal_data_o == 24'h7fffff)
		else $error("positive overflow not saturated");
	a_conv_clear: assert property (
		!conv_enable_i || standby_i |=> cal_data_o == 24'h000000 && conv_count_o == 2'h0)
		else $error("data not cleared when converter off");
	a_comp_off: assert property (
		!comp_en |=> !high_trip_flag_o && !low_trip_flag_o && !st_r.ff_valid)
		else $error("comparator active while disabled");
	a_restart_high: assert property (
		st_r.ff_valid && !($signed(st_r.ff_res) > $signed(high_trip_threshold_i))
		|=> st_r.cnt_h == 8'h00 && !high_trip_flag_o)
		else $error("high count not restarted");
	a_trip_single: assert property (
		ff_run && st_r.ff_valid && st_r.cfg[12:8] == 5'h00 &&
		high_trip_threshold_i != 16'h7fff &&
		$signed(st_r.ff_res) > $signed(high_trip_threshold_i) |=> high_trip_flag_o)
		else $error("single result did not trip");
	a_trip_two: assert property (
		st_r.cfg[12:8] == 5'h01 && st_r.ff_valid && st_r.cnt_h == 8'h00 |=> !high_trip_flag_o)
		else $error("code one tripped on first result");
	a_low_off: assert property (
		st_r.ff_valid && low_trip_threshold_i == 16'h8000 |=> !low_trip_flag_o)
		else $error("low detect not disabled");
	a_high_off: assert property (
		st_r.ff_valid && high_trip_threshold_i == 16'h7fff |=> !high_trip_flag_o)
		else $error("high detect not disabled");
	a_decim_rate: assert property (
		st_r.ff_valid |=> !st_r.ff_valid [*8])
		else $error("filter outputs too close together");
	a_pin_polarity: assert property (
		shared_pin_source_select_i && !shared_pin_format_i
		|=> overcurrent_fault_pin_o ==
		    ($past(fault_pol) ? ($past(high_trip_flag_o) || $past(low_trip_flag_o))
		                      : !($past(high_trip_flag_o) || $past(low_trip_flag_o))))
		else $error("fault pin level wrong");
	a_pin_gpio: assert property (
		!shared_pin_source_select_i && !shared_pin_format_i
		|=> overcurrent_fault_pin_o == $past(gpio_data_i) && overcurrent_fault_pin_oe_o)
		else $error("pin not following gpio data");
	a_cfg_lowbyte: assert property (
		reg_req_i.rd && reg_req_i.addr == 8'hc7 |=> reg_rdata_o[7:0] == 8'h00)
		else $error("config low byte not zero");
	a_cfg_store: assert property (
		reg_req_i.wr && reg_req_i.addr == 8'hc7 |=> st_r.cfg[7:0] == 8'h00)
		else $error("config low byte stored");
	a_gain_pos_lsb: assert property (
		conv_valid_i && conv_enable_i && !standby_i && st_r.gain == 16'h0001 &&
		conv_data_i == 24'h400000 |=> cal_data_o == 24'h400040)
		else $error("gain word 0001 is not one step above unity");
	a_gain_neg_lsb: assert property (
		conv_valid_i && conv_enable_i && !standby_i && st_r.gain == 16'hffff &&
		conv_data_i == 24'h400000 |=> cal_data_o == 24'h3fffc0)
		else $error("gain word ffff is not one step below unity");
	a_gain_max: assert property (
		conv_valid_i && conv_enable_i && !standby_i && st_r.gain == 16'h7fff &&
		conv_data_i == 24'h400000 |=> cal_data_o == 24'h5fffc0)
		else $error("largest gain word is not 1.499985");
	a_sat_low: assert property (
		conv_valid_i && conv_enable_i && !standby_i && !st_r.gain[15] &&
		conv_data_i == 24'h800000 |=> cal_data_o == 24'h800000)
		else $error("negative overflow not saturated");
	a_conv_gates_ff: assert property (
		!conv_enable_i || standby_i
		|=> !st_r.ff_valid && !high_trip_flag_o && !low_trip_flag_o)
		else $error("comparator active with converter off");
	a_restart_low: assert property (
		st_r.ff_valid && !($signed(st_r.ff_res) < $signed(low_trip_threshold_i))
		|=> st_r.cnt_l == 8'h00 && !low_trip_flag_o)
		else $error("low count not restarted");
	a_low_single: assert property (
		ff_run && st_r.ff_valid && st_r.cfg[12:8] == 5'h00 &&
		low_trip_threshold_i != 16'h8000 &&
		$signed(st_r.ff_res) < $signed(low_trip_threshold_i) |=> low_trip_flag_o)
		else $error("single low result did not trip");
	a_rise_high: assert property (
		$rose(high_trip_flag_o) |-> $past(st_r.ff_valid))
		else $error("high flag rose without a filter result");
	a_rise_low: assert property (
		$rose(low_trip_flag_o) |-> $past(st_r.ff_valid))
		else $error("low flag rose without a filter result");
	a_high_faults: assert property (
		high_trip_flag_o && fault_pol && shared_pin_source_select_i &&
		!shared_pin_format_i |=> overcurrent_fault_pin_o)
		else $error("high trip did not raise the fault");
	a_low_faults: assert property (
		low_trip_flag_o && !fault_pol && shared_pin_source_select_i &&
		!shared_pin_format_i |=> !overcurrent_fault_pin_o)
		else $error("low trip did not raise the fault");
	a_od_fault: assert property (
		shared_pin_source_select_i && shared_pin_format_i
		|=> !overcurrent_fault_pin_o &&
		    overcurrent_fault_pin_oe_o ==
		    ($past(fault_pol) ? !($past(high_trip_flag_o) || $past(low_trip_flag_o))
		                      : ($past(high_trip_flag_o) || $past(low_trip_flag_o))))
		else $error("open-drain fault pin wrong");

endmodule

// ==== test/sgc_host_model.sv ====
module sgc_host_model (
	input  wire logic keep_enable_i,
	input  wire logic fault_pin_i,
	input  wire logic fault_pin_oe_i,
	output wire logic conv_enable_o,
	output wire logic pin_level_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// ****************
	// host side of the fault pin
	// ****************
	// host never drops the converter unless a scenario asks it to
	assign conv_enable_o = keep_enable_i;
	// pull-up on the board: released open-drain reads high, not the last value
	assign pin_level_o   = fault_pin_oe_i ? fault_pin_i : 1'b1;
endmodule

// ==== test/sgc_shunt_cal_tb.sv ====
module sgc_shunt_cal_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [15:0] G_TAB [5] = '{16'h0000, 16'h7fff, 16'h8000, 16'hffff, 16'h0001};
	localparam logic [23:0] D_TAB [4] = '{24'h7fffff, 24'h800000, 24'h000001, 24'h400000};
	localparam logic [4:0]  C_TAB [8] = '{5'h00, 5'h01, 5'h07, 5'h08, 5'h0a, 5'h15, 5'h17, 5'h1f};
	localparam int          N_TAB [8] = '{1, 2, 8, 9, 12, 48, 64, 128};
	logic                  sys_clk_i    = 1'b0;
	logic                  nrst_i       = 1'b0;
	sgc_pkg::sgc_reg_req_t req          = '0;
	logic [15:0]           hi_th        = 16'h7fff;
	logic [15:0]           lo_th        = 16'h8000;
	logic [15:0]           lfsr         = 16'hc8ff;
	logic [15:0]           gain         = '0;
	logic [15:0]           cw           = '0;
	logic [23:0]           cd           = '0;
	logic                  keep         = 1'b1;
	logic                  stby         = 1'b0;
	logic                  cv           = 1'b0;
	logic                  stb          = 1'b0;
	logic                  mbit         = 1'b0;
	logic                  sel          = 1'b1;
	logic                  fmt          = 1'b0;
	logic                  gdat         = 1'b0;
	logic [1:0]            ecnt         = '0;
	logic [15:0]           rdata, rv;
	logic [23:0]           cal;
	logic [1:0]            ccnt;
	logic                  cal_v, hf, lf, pin, pin_oe, conv_en, lvl;
	int                    error_cnt    = 0;
	int                    total_checks = 0;
	int                    cycles       = 0;

	sgc_shunt_cal sgc_shunt_cal_i (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .reg_req_i(req),
		.reg_rdata_o(rdata), .conv_enable_i(conv_en), .standby_i(stby), .conv_valid_i(cv),
		.conv_data_i(cd), .cal_valid_o(cal_v), .cal_data_o(cal), .conv_count_o(ccnt),
		.mod_stb_i(stb), .mod_bit_i(mbit), .high_trip_threshold_i(hi_th),
		.low_trip_threshold_i(lo_th), .high_trip_flag_o(hf), .low_trip_flag_o(lf),
		.shared_pin_source_select_i(sel), .shared_pin_format_i(fmt), .gpio_data_i(gdat),
		.overcurrent_fault_pin_o(pin), .overcurrent_fault_pin_oe_o(pin_oe));
	sgc_host_model sgc_host_model_i (.keep_enable_i(keep), .fault_pin_i(pin),
		.fault_pin_oe_i(pin_oe), .conv_enable_o(conv_en), .pin_level_o(lvl));

	// ****************
	// checking and bus helpers
	// ****************
	task automatic give_verdict();
		if (error_cnt == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error %0t: word %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_cal(input logic [23:0] got, input logic [23:0] exp);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error %0t: result %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error %0t: bit %b expected %b", $time, got, exp);
		end
	endtask
	task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
		@(negedge sys_clk_i);
		req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(negedge sys_clk_i);
		req.wr = 1'b0;
	endtask
	task automatic reg_rd(input logic [7:0] a, output logic [15:0] d);
		@(negedge sys_clk_i);
		req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
		@(negedge sys_clk_i);
		req.rd = 1'b0;
		@(negedge sys_clk_i);
		d = rdata;
	endtask
	function automatic logic [15:0] rnd();
		lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		return lfsr;
	endfunction
	// floor shift then clamp, so wrap-around shows up as a mismatch
	function automatic logic [23:0] exp_cal(input logic [23:0] d, input logic [15:0] g);
		logic signed [47:0] p;
		p = 48'($signed(d)) * 48'($signed(g) + 18'sh10000);
		p = p >>> 16;
		if (p > 48'sh7fffff)
			return 24'h7fffff;
		if (p < -48'sh800000)
			return 24'h800000;
		return p[23:0];
	endfunction
	task automatic conv(input logic [23:0] d, input logic v);
		@(negedge sys_clk_i);
		cv = 1'b1;
		cd = d;
		@(negedge sys_clk_i);
		cv = 1'b0;
		ecnt = v ? ecnt + 2'h1 : 2'h0;
		chk_bit(cal_v, v);
		chk_cal(cal, v ? exp_cal(d, gain) : 24'h000000);
		chk_word({14'h0, ccnt}, {14'h0, ecnt});
	endtask
	// settle time covers strobe, filter result, flag and pin stages
	task automatic run(input int n);
		repeat (n * 64) begin
			@(negedge sys_clk_i);
			stb = 1'b1;
		end
		@(negedge sys_clk_i);
		stb = 1'b0;
		repeat (3) @(negedge sys_clk_i);
	endtask
	// steady sinc3 output of an all-ones stream is 4000, all-zeros c000
	task automatic trip(input logic [4:0] c, input int n, input logic pol, input logic up,
		input logic dis);
		reg_wr(8'hc7, 16'h0000);
		hi_th = 16'h7fff;
		lo_th = 16'h8000;
		mbit = up;
		reg_wr(8'hc7, {1'b1, pol, 1'b0, c, 8'h00});
		run(4);
		chk_bit(hf | lf, 1'b0);
		if (up)
			hi_th = 16'h3fff;
		else
			lo_th = 16'hc001;
		run(n - 1);
		chk_bit(up ? hf : lf, 1'b0);
		run(1);
		chk_bit(up ? hf : lf, 1'b1);
		chk_bit(lvl, pol);
		if (dis)
			reg_wr(8'hc7, 16'h0000);
		else if (up)
			hi_th = 16'h4000;
		else
			lo_th = 16'hc000;
		run(1);
		chk_bit(hf | lf, 1'b0);
		chk_bit(lvl, ~pol);
	endtask

	// ****************
	// clock, watchdog and main sequence
	// ****************
	initial begin
		forever #10 sys_clk_i = ~sys_clk_i;
	end
	always @(posedge sys_clk_i) begin
		cycles++;
		if (cycles == 60000) begin
			error_cnt++;
			give_verdict();
		end
	end
	initial begin
		repeat (10) @(posedge sys_clk_i);
		@(negedge sys_clk_i);
		nrst_i = 1'b1;
		reg_rd(8'hc6, rv);
		chk_word(rv, 16'h0000);
		reg_rd(8'hc7, rv);
		chk_word(rv, 16'h0000);
		repeat (8) begin
			gain = rnd();
			cw = rnd() & 16'hdfff;
			reg_wr(8'hc6, gain);
			reg_wr(8'hc8, rnd());
			reg_wr(8'hc7, cw);
			reg_rd(8'hc6, rv);
			chk_word(rv, gain);
			reg_rd(8'hc7, rv);
			chk_word(rv, cw & 16'hff00);
		end
		for (int i = 0; i < 5; i++) begin
			gain = G_TAB[i];
			reg_wr(8'hc6, gain);
			for (int j = 0; j < 4; j++)
				conv(D_TAB[j], 1'b1);
		end
		repeat (20) begin
			gain = rnd();
			reg_wr(8'hc6, gain);
			conv(24'({rnd(), rnd()}), 1'b1);
		end
		keep = 1'b0;
		conv(24'h123456, 1'b0);
		keep = 1'b1;
		stby = 1'b1;
		conv(24'h654321, 1'b0);
		stby = 1'b0;
		conv(24'h000100, 1'b1);
		for (int i = 0; i < 8; i++)
			trip(C_TAB[i], N_TAB[i], i[0], i[1], i == 4);
		// single-result trip, then hold the fault while the pin format and source change
		hi_th = 16'h3fff;
		reg_wr(8'hc7, 16'h8000);
		run(1);
		chk_bit(hf, 1'b1);
		chk_bit(lvl, 1'b0);
		fmt = 1'b1;
		repeat (2) @(negedge sys_clk_i);
		chk_bit(lvl, 1'b0);
		chk_bit(pin_oe, 1'b1);
		sel = 1'b0;
		for (int i = 0; i < 4; i++) begin
			@(negedge sys_clk_i);
			fmt = i[1];
			gdat = i[0];
			repeat (2) @(negedge sys_clk_i);
			chk_bit(lvl, gdat);
			chk_bit(pin_oe, fmt ? ~gdat : 1'b1);
		end
		chk_bit(hf, 1'b1);
		give_verdict();
	end
endmodule
